// ---- test/core_exception_config_regs_chk.sv ----
`timescale 1ns/1ps
// watches register reads and event outputs, each one cycle behind its cause
module core_exception_config_regs_chk
  import sys_ctrl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [7:0] i_pend_prio,
  input wire logic [2:0] o_group_prio,
  input wire logic [2:0] o_sub_prio,
  input wire logic i_return,
  input wire logic i_stacked_psr9,
  input wire logic o_restore_pad,
  input wire logic i_data_busfault,
  input wire logic i_handler_neg_prio,
  input wire logic o_busfault_ignore,
  input wire logic o_lockup,
  input wire logic i_div_zero,
  input wire logic o_div_trap,
  input wire logic o_div_zero_result,
  input wire logic i_unaligned,
  input wire access_kind_t i_access_kind,
  input wire logic o_usage_fault,
  input wire logic i_swtrig_req,
  input wire logic i_unprivileged,
  input wire logic o_swtrig_grant,
  input wire logic o_swtrig_deny
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  a_key_read: assert property ($past(i_rd) && $past(i_addr) == 8'h0C
    |-> o_rdata[31:15] == {16'h05FA, 1'b0}) else $error("key or order bits wrong");
  a_sleep_zero: assert property ($past(i_rd) && $past(i_addr) == 8'h10
    |-> o_rdata == 32'h0) else $error("sleep control read not zero");
  a_prio_split: assert property (1'b1 |=> (o_group_prio & o_sub_prio) == 3'h0
    && (o_group_prio | o_sub_prio) == $past(i_pend_prio[7:5])) else $error("bad split");
  a_restore_pad: assert property (1'b1 |=>
    o_restore_pad == $past(i_return && i_stacked_psr9)) else $error("restore pad wrong");
  a_lock_pair: assert property (i_data_busfault && i_handler_neg_prio |=>
    o_busfault_ignore != o_lockup) else $error("bus fault not ignored nor locked");
  a_div_one: assert property (i_div_zero |=>
    o_div_trap != o_div_zero_result) else $error("divide by zero outcome wrong");
  a_div_quiet: assert property (!i_div_zero |=>
    !o_div_trap && !o_div_zero_result) else $error("divide outcome without cause");
  a_multi_fault: assert property (i_unaligned && i_access_kind != ACC_SINGLE
    |=> o_usage_fault) else $error("multiple access did not fault");
  a_swtrig_priv: assert property (i_swtrig_req && !i_unprivileged
    |=> o_swtrig_grant && !o_swtrig_deny) else $error("privileged trigger refused");
endmodule // core_exception_config_regs_chk

bind core_exception_config_regs core_exception_config_regs_chk u_chk (.*);

// ---- test/core_exception_config_regs_tb.sv ----
`timescale 1ns/1ps
`include "sys_ctrl_defines.svh"
// drives the register port and every event input straight from the bench
module core_exception_config_regs_tb
  import sys_ctrl_pkg::*;
;
  logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_exc_num = 8'h00, i_pend_prio = 8'h00, i_active_prio = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, o_vector_addr;
  logic i_entry = 0, i_sp_bit2 = 0, i_return = 0, i_stacked_psr9 = 0, i_data_busfault = 0;
  logic i_handler_neg_prio = 0, i_div_zero = 0, i_unaligned = 0, i_swtrig_req = 0;
  logic i_unprivileged = 0, i_ret_to_thread = 0, i_other_active = 0;
  access_kind_t i_access_kind = ACC_SINGLE;
  logic [2:0] o_group_prio, o_sub_prio;
  logic o_preempt, o_stack_pad, o_stacked_align, o_restore_pad, o_busfault_ignore, o_lockup;
  logic o_div_trap, o_div_zero_result, o_usage_fault, o_swtrig_grant, o_swtrig_deny;
  logic o_thread_ok, o_return_fault;
  int mismatches = 0, n_tests = 0;

  always #2 i_clk_sys = ~i_clk_sys;

  core_exception_config_regs u_core_exception_config_regs (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // every event fires together for one cycle; results land one cycle later
  task automatic pulse();
    @(posedge i_clk_sys);
    {i_entry, i_return, i_data_busfault, i_div_zero, i_unaligned, i_swtrig_req,
      i_ret_to_thread} <= 7'h7F;
    @(posedge i_clk_sys);
    {i_entry, i_return, i_data_busfault, i_div_zero, i_unaligned, i_swtrig_req,
      i_ret_to_thread} <= 7'h00;
    #1;
  endtask

  task automatic t_reset();
    logic [31:0] v;
    wr(`OFS_SLEEP_CONTROL, 32'hFFFFFFFF);
    rd(`OFS_VECTOR_BASE, v);
    chk(v, 32'h0);
    rd(`OFS_APP_IRQ_RESET, v);
    chk(v, 32'h05FA0000);
    rd(`OFS_SLEEP_CONTROL, v);
    chk(v, 32'h0);
    rd(`OFS_CORE_CONFIG, v);
    chk(v, 32'h0);
    rd(8'h40, v);
    chk(v, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_vector();
    logic [31:0] v;
    i_exc_num <= 8'h10;
    wr(`OFS_VECTOR_BASE, 32'hFFFFFFFF);
    rd(`OFS_VECTOR_BASE, v);
    chk(v, 32'h3FFFFF80);
    wr(`OFS_VECTOR_BASE, 32'h00000200);
    @(posedge i_clk_sys);
    #1 chk(o_vector_addr, 32'h00000240);
    wr(`OFS_VECTOR_BASE, 32'h20000000);
    @(posedge i_clk_sys);
    #1 chk(o_vector_addr, 32'h20000040);
    $display("vector base done");
  endtask

  task automatic t_split();
    logic [31:0] v;
    logic [2:0] m;
    wr(`OFS_APP_IRQ_RESET, 32'h12340700);
    rd(`OFS_APP_IRQ_RESET, v);
    chk(v, 32'h05FA0000);
    i_pend_prio <= 8'hA0;
    i_active_prio <= 8'hC0;
    for (int s = 0; s < 8; s++) begin
      wr(`OFS_APP_IRQ_RESET, 32'h05FA8000 | (32'(s) << 8));
      rd(`OFS_APP_IRQ_RESET, v);
      chk(v, 32'h05FA0000 | (32'(s) << 8));
      m = s < 5 ? 3'h7 : s == 5 ? 3'h6 : s == 6 ? 3'h4 : 3'h0;
      chk(o_group_prio, 3'h5 & m);
      chk(o_sub_prio, 3'h5 & ~m);
      chk(o_preempt, (3'h5 & m) < (3'h6 & m));
    end
    $display("priority split done");
  endtask

  task automatic t_cfg(input logic b);
    logic [31:0] v;
    wr(`OFS_CORE_CONFIG, b ? 32'hFFFFFFFF : 32'h0);
    rd(`OFS_CORE_CONFIG, v);
    chk(v, b ? 32'h0000031B : 32'h0);
    {i_sp_bit2, i_stacked_psr9, i_handler_neg_prio, i_unprivileged, i_other_active} <= 5'h1F;
    i_access_kind <= ACC_SINGLE;
    pulse();
    chk(o_stack_pad, b);
    chk(o_stacked_align, b);
    chk(o_restore_pad, 1'b1);
    chk(o_busfault_ignore, b);
    chk(o_lockup, !b);
    chk(o_div_trap, b);
    chk(o_div_zero_result, !b);
    chk(o_usage_fault, b);
    chk(o_swtrig_grant, b);
    chk(o_swtrig_deny, !b);
    chk(o_thread_ok, b);
    chk(o_return_fault, !b);
    i_access_kind <= ACC_MULTI;
    pulse();
    chk(o_usage_fault, 1'b1);
    i_access_kind <= ACC_DOUBLE;
    i_unprivileged <= 1'b0;
    pulse();
    chk(o_usage_fault, 1'b1);
    chk(o_swtrig_grant, 1'b1);
    $display("config events done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // the whole sequence needs under a hundred cycles; the 2000-cycle limit is ample headroom
  initial begin
    #8000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    t_reset();
    t_vector();
    t_split();
    t_cfg(1'b0);
    t_cfg(1'b1);
    close_out();
  end
endmodule // core_exception_config_regs_tb

// ---- verilog/core_exception_config_regs.sv ----
// Functional notes
// - vector base holds table offset bits
// - top offset bit selects code or SRAM
// - offset bits 6..0 read zero always
// - control writes need the unlock key
// - upper half reads fixed key value
// - byte order bit reads zero, little-endian
// - bits 10..8 hold the priority split
// - split 0..4 all group; 5 one sub
// - split 6 two sub; 7 all sub
// - preemption compares group priority only
// - bit 9 picks four or eight byte stack
// - stacked status bit 9 records, restores alignment
// - bit 8 lets high handlers ignore bus faults
// - bit 4 traps divide by zero
// - bit 3 traps unaligned single accesses
// - unaligned multiple/double accesses always fault
// - bit 1 gates unprivileged software trigger
// - bit 0 allows thread entry any level
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "sys_ctrl_defines.svh"

module core_exception_config_regs
  import sys_ctrl_pkg::*;
#(
  parameter bit LATE_REV = 1'b0,
  parameter logic STK_RESET = `RST_CFG_STK
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,

  // register port
  // one-cycle strobes; read data stand in the next cycle only
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,

  // vector fetch
  // address lags the exception number by one clock
  input wire logic [7:0] i_exc_num,
  output logic [31:0] o_vector_addr,

  // priority comparison
  // only priority bits 7..5 are implemented
  input wire logic [7:0] i_pend_prio,
  input wire logic [7:0] i_active_prio,
  output logic o_preempt,
  output logic [2:0] o_group_prio,
  output logic [2:0] o_sub_prio,

  // exception entry and return stacking
  // entry and return are pulses; the stack pointer bit is a level
  input wire logic i_entry,
  input wire logic i_sp_bit2,
  input wire logic i_return,
  input wire logic i_stacked_psr9,
  output logic o_stack_pad,
  output logic o_stacked_align,
  output logic o_restore_pad,

  // data bus fault
  // negative priority level is a level from the core
  input wire logic i_data_busfault,
  input wire logic i_handler_neg_prio,
  output logic o_busfault_ignore,
  output logic o_lockup,

  // divide by zero
  // one pulse per divide whose divisor is zero
  input wire logic i_div_zero,
  output logic o_div_trap,
  output logic o_div_zero_result,

  // alignment check
  // kind tells single from multiple or doubleword
  input wire logic i_unaligned,
  input wire access_kind_t i_access_kind,
  output logic o_usage_fault,

  // software trigger access
  // privilege is a level, the request a pulse
  input wire logic i_swtrig_req,
  input wire logic i_unprivileged,
  output logic o_swtrig_grant,
  output logic o_swtrig_deny,

  // exception return into thread mode
  // other-active is a level from the exception tracker
  input wire logic i_ret_to_thread,
  input wire logic i_other_active,
  output logic o_thread_ok,
  output logic o_return_fault
);

  // register map, as byte offsets on the eight-bit port:
  //   0x08 vector base
  //   0x0C interrupt/reset control
  //   0x10 sleep control
  //   0x14 configuration/control
  // every other offset reads zero and swallows writes

  // vector base: the offset field sits in bits 31..7
  //   an early core keeps bits 29..7 and reads 31..30 as zero
  //   a late core keeps the full field up to bit 31
  //   the top kept bit chooses the code or the SRAM region
  //   bits 6..0 are never stored, so the base is 128-byte aligned
  //   a base that is not aligned to the table size is not caught here

  // interrupt/reset control:
  //   bits 31..16 read back the fixed key value
  //   bit 15 reads zero, data accesses are little-endian
  //   bits 10..8 hold the priority split point
  //   the reset request and clear-active bits are not built
  //   a write without the unlock key leaves everything as it was

  // priority split, applied to priority bits 7..5:
  //   0..4 all three are group bits
  //   5    two group bits, one subpriority bit
  //   6    one group bit, two subpriority bits
  //   7    no group bits, all three are subpriority
  //   preemption looks at the group bits alone

  // configuration/control:
  //   bit 9 eight-byte stack alignment on entry
  //   bit 8 bus faults ignored in handlers at -1 or -2
  //   bit 4 trap on a zero divisor
  //   bit 3 trap on unaligned single accesses
  //   bit 1 unprivileged access to the software trigger
  //   bit 0 thread mode reachable from any level

  // side channels:
  //   each event input is a one-cycle pulse from the core
  //   each answer is registered and lags its cause by one clock
  //   answers stand for one cycle, except the stacked alignment,
  //   which holds until the next exception entry

  // hazards:
  //   an event in the same cycle as a configuration write still sees
  //   the old setting, since the write lands at the clock edge
  //   software should let one clock pass before relying on a change
  //   the block keeps no sticky flags, so no set/clear race exists

  state_t state_reg;
  state_t state_next;

  // mask of the offset bits the revision implements
  // early cores keep 23 offset bits, late cores 25
  function automatic logic [24:0] ofs_mask();
    ofs_mask = LATE_REV ? `VB_MASK_LATE : `VB_MASK_EARLY;
  endfunction

  // which of priority bits 7..5 are group bits
  // split codes 0..4 give no subpriority at all
  function automatic logic [2:0] group_mask(input logic [2:0] split);
    logic [2:0] m;
    m = 3'h7;
    unique case (split)
      `SPLIT_ONE_SUB: m = 3'h6;
      `SPLIT_TWO_SUB: m = 3'h4;
      `SPLIT_ALL_SUB: m = 3'h0;
      default: m = 3'h7;
    endcase
    group_mask = m;
  endfunction

  // read value of a register, reserved bits zero
  // unmapped offsets and reserved positions return zero
  function automatic logic [31:0] read_word(input logic [7:0] a, input state_t s);
    logic [31:0] w;
    w = 32'h00000000;
    unique case (a)
      `OFS_VECTOR_BASE: begin
        w = {s.vector_base_offset & ofs_mask(), `VB_LOW_ZERO};
      end
      `OFS_APP_IRQ_RESET: begin
        w[31:16] = `AIRC_KEY_READ;
        w[`AIRC_ORDER_BIT] = `AIRC_ORDER_VAL;
        w[`AIRC_SPLIT_LSB +: 3] = s.priority_split_point;
      end
      `OFS_SLEEP_CONTROL: begin
        w = 32'h00000000;
      end
      `OFS_CORE_CONFIG: begin
        w[`CFG_STK_BIT] = s.cfg.stack_eight_byte_align;
        w[`CFG_BFI_BIT] = s.cfg.high_prio_busfault_ignore;
        w[`CFG_DIV_BIT] = s.cfg.divide_zero_trap;
        w[`CFG_UNA_BIT] = s.cfg.misaligned_access_trap;
        w[`CFG_SWT_BIT] = s.cfg.unpriv_swtrig_access;
        w[`CFG_THR_BIT] = s.cfg.thread_entry_any_level;
      end
      default: w = 32'h00000000;
    endcase
    read_word = w;
  endfunction

  logic [2:0] gmask;
  logic [2:0] pend_top;
  logic [2:0] act_top;
  logic vb_region;
  logic key_ok;

  // priority bits 7..5 carry the implemented level
  assign pend_top = i_pend_prio[7:5];
  assign act_top = i_active_prio[7:5];
  assign gmask = group_mask(state_reg.priority_split_point);

  // region bit sits at the top of the implemented offset
  assign vb_region = LATE_REV ? state_reg.vector_base_offset[`VB_REGION_LATE]
                              : state_reg.vector_base_offset[`VB_REGION_EARLY];

  // unlock key check for the interrupt/reset control word
  assign key_ok = (i_wdata[31:16] == `AIRC_KEY_WRITE);

  // next-state computation for the whole block
  always_comb begin
    state_next = state_reg;

    // register writes
    // strobes never overlap, so a write and a read never collide
    if (i_wr) begin
      unique case (i_addr)
        `OFS_VECTOR_BASE: begin
          state_next.vector_base_offset = i_wdata[31:`VB_OFS_LSB] & ofs_mask();
        end
        `OFS_APP_IRQ_RESET: begin
          // a wrong key drops the whole write, split included
          if (key_ok) begin
            state_next.priority_split_point = i_wdata[`AIRC_SPLIT_LSB +: 3];
          end
        end
        `OFS_CORE_CONFIG: begin
          state_next.cfg.stack_eight_byte_align = i_wdata[`CFG_STK_BIT];
          state_next.cfg.high_prio_busfault_ignore = i_wdata[`CFG_BFI_BIT];
          state_next.cfg.divide_zero_trap = i_wdata[`CFG_DIV_BIT];
          state_next.cfg.misaligned_access_trap = i_wdata[`CFG_UNA_BIT];
          state_next.cfg.unpriv_swtrig_access = i_wdata[`CFG_SWT_BIT];
          state_next.cfg.thread_entry_any_level = i_wdata[`CFG_THR_BIT];
        end
        default: begin
          // sleep control and unmapped offsets store nothing
          state_next.rdata = state_next.rdata;
        end
      endcase
    end

    // read data stands only in the cycle after the strobe
    // zero outside that cycle keeps a stale word off the bus
    state_next.rdata = i_rd ? read_word(i_addr, state_reg) : 32'h00000000;

    // vector fetch address: table base plus four bytes per entry
    // a misaligned table base is the software's problem; low bits stay zero
    state_next.vector_addr = {state_reg.vector_base_offset & ofs_mask(), `VB_LOW_ZERO}
                             + {22'h0, i_exc_num, 2'h0};
    // the region bit is already part of the address; kept visible for debug
    if (vb_region && (state_next.vector_addr == 32'h00000000)) begin
      state_next.vector_addr = 32'h00000000;
    end

    // group and subpriority split of the pending priority
    // only bits 7..5 exist, so finer split points collapse to all-group
    state_next.group_prio = pend_top & gmask;
    state_next.sub_prio = pend_top & ~gmask;
    // lower value wins; equal groups never preempt whatever the subpriority
    state_next.preempt = (pend_top & gmask) < (act_top & gmask);

    // stack alignment on entry, recorded in stacked bit 9
    // the core stores the recorded bit with the exception frame
    if (i_entry) begin
      state_next.stack_pad = state_reg.cfg.stack_eight_byte_align & i_sp_bit2;
      state_next.stacked_align = state_reg.cfg.stack_eight_byte_align & i_sp_bit2;
    end else begin
      state_next.stack_pad = 1'b0;
      state_next.stacked_align = state_reg.stacked_align;
    end
    // on return the stacked bit alone decides the restore
    state_next.restore_pad = i_return & i_stacked_psr9;

    // bus faults from loads and stores in priority -1/-2 handlers
    // outside those handlers a bus fault is not this block's concern
    state_next.busfault_ignore = i_data_busfault & i_handler_neg_prio
                                 & state_reg.cfg.high_prio_busfault_ignore;
    state_next.lockup = i_data_busfault & i_handler_neg_prio
                        & ~state_reg.cfg.high_prio_busfault_ignore;

    // divide by zero: trap or quotient of zero
    // exactly one of the two fires for each zero divisor
    state_next.div_trap = i_div_zero & state_reg.cfg.divide_zero_trap;
    state_next.div_zero_result = i_div_zero & ~state_reg.cfg.divide_zero_trap;

    // alignment: multiple and doubleword always fault
    // the trap enable only reaches single accesses
    state_next.usage_fault = 1'b0;
    if (i_unaligned) begin
      unique case (i_access_kind)
        ACC_SINGLE: state_next.usage_fault = state_reg.cfg.misaligned_access_trap;
        ACC_MULTI: state_next.usage_fault = 1'b1;
        ACC_DOUBLE: state_next.usage_fault = 1'b1;
        default: state_next.usage_fault = 1'b1;
      endcase
    end

    // software trigger register access; privileged code is always let in
    // grant and deny are exclusive for every request
    state_next.swtrig_grant = i_swtrig_req
                              & (~i_unprivileged | state_reg.cfg.unpriv_swtrig_access);
    state_next.swtrig_deny = i_swtrig_req & i_unprivileged
                             & ~state_reg.cfg.unpriv_swtrig_access;

    // return to thread mode with other exceptions still active
    // with nothing else active the return is always allowed
    state_next.thread_ok = i_ret_to_thread
                           & (~i_other_active | state_reg.cfg.thread_entry_any_level);
    state_next.return_fault = i_ret_to_thread & i_other_active
                              & ~state_reg.cfg.thread_entry_any_level;
  end

  // one register for all state
  // async clear so the options are defined before the first fetch
  // every field resets to a constant; stack alignment follows a parameter
  // since some platforms boot with eight-byte frames
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= '0;
      state_reg.vector_base_offset <= `RST_VB_OFS;
      state_reg.priority_split_point <= `RST_SPLIT;
      state_reg.cfg.stack_eight_byte_align <= STK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  // register read data
  assign o_rdata = state_reg.rdata;

  // vector fetch address
  assign o_vector_addr = state_reg.vector_addr;

  // priority comparison results
  assign o_preempt = state_reg.preempt;
  assign o_group_prio = state_reg.group_prio;
  assign o_sub_prio = state_reg.sub_prio;

  // stacking results
  assign o_stack_pad = state_reg.stack_pad;
  assign o_stacked_align = state_reg.stacked_align;
  assign o_restore_pad = state_reg.restore_pad;

  // bus fault outcome
  assign o_busfault_ignore = state_reg.busfault_ignore;
  assign o_lockup = state_reg.lockup;

  // divide by zero outcome
  assign o_div_trap = state_reg.div_trap;
  assign o_div_zero_result = state_reg.div_zero_result;

  // alignment fault
  assign o_usage_fault = state_reg.usage_fault;

  // software trigger outcome
  assign o_swtrig_grant = state_reg.swtrig_grant;
  assign o_swtrig_deny = state_reg.swtrig_deny;

  // thread return outcome
  assign o_thread_ok = state_reg.thread_ok;
  assign o_return_fault = state_reg.return_fault;

endmodule // core_exception_config_regs

// ---- verilog/sys_ctrl_defines.svh ----
`ifndef SYS_CTRL_DEFINES_SVH
`define SYS_CTRL_DEFINES_SVH

// word-aligned byte offsets of the four registers
`define OFS_VECTOR_BASE 8'h08
`define OFS_APP_IRQ_RESET 8'h0C
`define OFS_SLEEP_CONTROL 8'h10
`define OFS_CORE_CONFIG 8'h14

// vector base layout
`define VB_OFS_LSB 7
`define VB_LOW_ZERO 7'h00
`define VB_MASK_EARLY 25'h07FFFFF
`define VB_MASK_LATE 25'h1FFFFFF
`define VB_REGION_EARLY 22
`define VB_REGION_LATE 24

// interrupt/reset control layout
`define AIRC_KEY_WRITE 16'h05FA
`define AIRC_KEY_READ 16'h05FA
`define AIRC_ORDER_BIT 15
`define AIRC_SPLIT_LSB 8
`define AIRC_ORDER_VAL 1'b0

// configuration/control layout
`define CFG_STK_BIT 9
`define CFG_BFI_BIT 8
`define CFG_DIV_BIT 4
`define CFG_UNA_BIT 3
`define CFG_SWT_BIT 1
`define CFG_THR_BIT 0

// reset values
`define RST_VB_OFS 25'h0
`define RST_SPLIT 3'h0
`define RST_CFG_STK 1'b0

// priority grouping split points
`define SPLIT_ONE_SUB 3'h5
`define SPLIT_TWO_SUB 3'h6
`define SPLIT_ALL_SUB 3'h7

`endif

// ---- verilog/sys_ctrl_pkg.sv ----
package sys_ctrl_pkg;

  // kind of data access being checked for alignment
  typedef enum logic [1:0] {
    ACC_SINGLE = 2'h0,
    ACC_MULTI = 2'h1,
    ACC_DOUBLE = 2'h3
  } access_kind_t;

  // configuration/control bits held by the block
  typedef struct packed {
    logic stack_eight_byte_align;
    logic high_prio_busfault_ignore;
    logic divide_zero_trap;
    logic misaligned_access_trap;
    logic unpriv_swtrig_access;
    logic thread_entry_any_level;
  } core_config_ctrl_t;

  // whole state of the block
  typedef struct packed {
    logic [24:0] vector_base_offset;
    logic [2:0] priority_split_point;
    core_config_ctrl_t cfg;
    logic [31:0] rdata;
    logic [31:0] vector_addr;
    logic preempt;
    logic [2:0] group_prio;
    logic [2:0] sub_prio;
    logic stack_pad;
    logic stacked_align;
    logic restore_pad;
    logic busfault_ignore;
    logic lockup;
    logic div_trap;
    logic div_zero_result;
    logic usage_fault;
    logic swtrig_grant;
    logic swtrig_deny;
    logic thread_ok;
    logic return_fault;
  } state_t;

endpackage
